// ===== logic/sdh_pkg.sv
// sdh_pkg: constants for the single-wire debug serial handshake block
// assumes the serial clock i_clk is the target serial clock (20 MHz)
package sdh_pkg;
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned BIT_CYCLES      = 16;
	localparam int unsigned TIMEOUT_CYCLES  = 512;
	localparam int unsigned RX_SAMPLE_CYC   = 10;
	localparam int unsigned TX_ONE_PULSE    = 7;
	localparam int unsigned TX_ZERO_PULSE   = 13;
	localparam int unsigned ACK_LOW_CYCLES  = 16;
	localparam int unsigned ACK_MIN_GAP     = 32;
	localparam int unsigned OPCODE_BITS     = 8;
	localparam int unsigned WORD_BITS       = 16;
	localparam int unsigned CNT_W           = 10;
	localparam logic [CNT_W-1:0] CNT_RESET  = 10'h000;
	localparam logic [4:0]  BITN_RESET      = 5'h00;

	typedef enum logic [2:0]
	{
		SDH_IDLE   = 3'b000,
		SDH_RX     = 3'b001,
		SDH_TX     = 3'b011,
		SDH_WAIT   = 3'b010,
		SDH_ACKLO  = 3'b110,
		SDH_ACKHI  = 3'b111
	} sdh_state_t;
endpackage

// ===== logic/sdh_edge_sync.sv
// sdh_edge_sync: two-flop synchroniser for the debug pin plus falling-edge detect
// assumes i_pin is asynchronous to i_clk
`timescale 1ns/1ns
module sdh_edge_sync
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_fall
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic prev_q;
	logic prev_d;

	always_comb
	begin
		meta_d = i_pin;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// no reset on the two synchroniser flops: the pin level held during reset must reach the mode strap
	always_ff @(posedge i_clk)
	begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	// idle level is high, so a pin left high through reset gives no false edge; one held low in reset shows a fall just after release
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			prev_q <= 1'b1;
		else
			prev_q <= prev_d;
	end

	// edge seen from the second flop only, within a cycle of the synchronised level
	assign o_level = sync_q;
	assign o_fall  = prev_q & ~sync_q;
endmodule

// ===== logic/sdh_serial.sv
// sdh_serial: target-side bit engine and acknowledge pulse generator on the debug serial pin
// assumes i_clk is the target serial clock; command decode and bus access live outside
// Behaviour
// - msb first, sixteen cycles per bit
// - 512 idle cycles between edges: timeout
// - pin driven low or brief high only
// - edge synchronised, delays counted from it
// - received bit sampled ten cycles after start
// - sent one: speedup pulse at cycle seven
// - sent zero: low thirteen cycles then speedup
// - ack: own edge, sixteen low, speedup
// - ack no sooner than 32 after end
// - ack delay unbounded, no maximum assumed
// - stop before execution discards pending command
// - byte read fetched, then ack issued
// - no nested acks, host aborts first
// - no internal ack timeout
// - pin is mode strap during reset
// - handshake off after reset, set by commands
// - commands: opcode, then address/data words
`timescale 1ns/1ns
module sdh_serial
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_pin,
	output logic             o_pin,
	output logic             o_pin_oe,
	output logic             o_mode_strap,
	input  wire logic        i_ack_enable,
	input  wire logic        i_ack_disable,
	input  wire logic        i_rx_arm,
	input  wire logic [4:0]  i_rx_bits,
	output logic             o_rx_valid,
	output logic [15:0]      o_rx_data,
	input  wire logic        i_tx_load,
	input  wire logic [4:0]  i_tx_bits,
	input  wire logic [15:0] i_tx_data,
	output logic             o_tx_done,
	input  wire logic        i_cmd_executed,
	input  wire logic        i_cpu_stop,
	output logic             o_ack_enabled,
	output logic             o_ack_pending,
	output logic             o_timeout,
	output logic             o_busy
);
	logic                          pin_level;
	logic                          pin_fall;
	sdh_pkg::sdh_state_t           state_q;
	sdh_pkg::sdh_state_t           state_d;
	logic [sdh_pkg::CNT_W-1:0]     cnt_q;
	logic [sdh_pkg::CNT_W-1:0]     cnt_d;
	logic [sdh_pkg::CNT_W-1:0]     idle_q;
	logic [sdh_pkg::CNT_W-1:0]     idle_d;
	logic [4:0]                    left_q;
	logic [4:0]                    left_d;
	logic [15:0]                   shift_q;
	logic [15:0]                   shift_d;
	logic                          txmode_q;
	logic                          txmode_d;
	logic                          ack_en_q;
	logic                          ack_en_d;
	logic                          pend_q;
	logic                          pend_d;
	logic                          gap_ok_q;
	logic                          gap_ok_d;
	logic                          strap_q;
	logic                          strap_d;
	logic                          in_rst_q;
	logic                          rx_valid_q;
	logic                          rx_valid_d;
	logic                          tx_done_q;
	logic                          tx_done_d;
	logic                          tmo_q;
	logic                          tmo_d;
	logic                          drv_q;
	logic                          drv_d;
	logic                          oe_q;
	logic                          oe_d;
	logic                          cur_bit;

	sdh_edge_sync u_sync
	(
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_pin   (i_pin),
		.o_level (pin_level),
		.o_fall  (pin_fall)
	);

	assign cur_bit = shift_q[15];

	always_comb
	begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		idle_d     = idle_q;
		left_d     = left_q;
		shift_d    = shift_q;
		txmode_d   = txmode_q;
		ack_en_d   = ack_en_q;
		pend_d     = pend_q;
		gap_ok_d   = gap_ok_q;
		rx_valid_d = 1'b0;
		tx_done_d  = 1'b0;
		tmo_d      = 1'b0;
		drv_d      = 1'b0;
		oe_d       = 1'b0;
		// handshake enable follows the dedicated commands, cleared by reset
		if (i_ack_enable)
			ack_en_d = 1'b1;
		else if (i_ack_disable)
			ack_en_d = 1'b0;
		// pending command: set on execution request wins over a stop discard
		if (i_cmd_executed && ack_en_q)
			pend_d = 1'b1;
		else if (i_cpu_stop)
			pend_d = 1'b0;
		// gap counter since last command end; saturates, never times out the ack
		if (idle_q != sdh_pkg::CNT_RESET && !gap_ok_q)
		begin
			idle_d = idle_q - 10'h001;
			if (idle_q == 10'h001)
				gap_ok_d = 1'b1;
		end
		if (i_rx_arm && left_q == 5'h00)
		begin
			left_d   = i_rx_bits;
			txmode_d = 1'b0;
			shift_d  = 16'h0000;
		end
		else if (i_tx_load && left_q == 5'h00)
		begin
			left_d   = i_tx_bits;
			txmode_d = 1'b1;
			// left-justify so the msb of the word leaves first
			shift_d  = i_tx_data << (5'd16 - i_tx_bits);
		end
		case (state_q)
			sdh_pkg::SDH_IDLE:
			begin
				cnt_d = (cnt_q == sdh_pkg::CNT_RESET) ? cnt_q : cnt_q + 10'h001;
				if (left_q != 5'h00 && cnt_q == 10'(sdh_pkg::TIMEOUT_CYCLES - 1))
				begin
					tmo_d  = 1'b1;
					left_d = 5'h00;
					cnt_d  = sdh_pkg::CNT_RESET;
				end
				else if (pin_fall && left_q != 5'h00)
				begin
					// host opens the bit; count from the perceived edge
					cnt_d   = 10'h001;
					state_d = txmode_q ? sdh_pkg::SDH_TX : sdh_pkg::SDH_RX;
					// a zero is held low from the perceived start, so the pin never floats up after host release
					oe_d    = txmode_q & ~cur_bit;
				end
				else if (pend_q && gap_ok_q && left_q == 5'h00)
				begin
					// own falling edge opens the acknowledge pulse
					cnt_d   = sdh_pkg::CNT_RESET;
					state_d = sdh_pkg::SDH_ACKLO;
					oe_d    = 1'b1;
				end
			end
			sdh_pkg::SDH_RX:
			begin
				cnt_d = cnt_q + 10'h001;
				if (cnt_q == 10'(sdh_pkg::RX_SAMPLE_CYC))
					shift_d = {shift_q[14:0], pin_level};
				if (cnt_q == 10'(sdh_pkg::BIT_CYCLES))
				begin
					left_d  = left_q - 5'h01;
					cnt_d   = 10'h001;
					state_d = sdh_pkg::SDH_IDLE;
					if (left_q == 5'h01)
					begin
						rx_valid_d = 1'b1;
						idle_d     = 10'(sdh_pkg::ACK_MIN_GAP);
						gap_ok_d   = 1'b0;
					end
				end
			end
			sdh_pkg::SDH_TX:
			begin
				cnt_d = cnt_q + 10'h001;
				// one: release, pulse at seven; zero: low to thirteen, then pulse
				if (cur_bit)
				begin
					if (cnt_q == 10'(sdh_pkg::TX_ONE_PULSE - 1))
					begin
						drv_d = 1'b1;
						oe_d  = 1'b1;
					end
				end
				else if (cnt_q < 10'(sdh_pkg::TX_ZERO_PULSE - 1))
					oe_d = 1'b1;
				else if (cnt_q == 10'(sdh_pkg::TX_ZERO_PULSE - 1))
				begin
					drv_d = 1'b1;
					oe_d  = 1'b1;
				end
				if (cnt_q == 10'(sdh_pkg::BIT_CYCLES))
				begin
					shift_d = {shift_q[14:0], 1'b0};
					left_d  = left_q - 5'h01;
					cnt_d   = 10'h001;
					state_d = sdh_pkg::SDH_IDLE;
					if (left_q == 5'h01)
						tx_done_d = 1'b1;
				end
			end
			sdh_pkg::SDH_ACKLO:
			begin
				cnt_d = cnt_q + 10'h001;
				oe_d  = 1'b1;
				if (cnt_q == 10'(sdh_pkg::ACK_LOW_CYCLES - 1))
				begin
					drv_d   = 1'b1;
					state_d = sdh_pkg::SDH_ACKHI;
				end
			end
			sdh_pkg::SDH_ACKHI:
			begin
				if (!(i_cmd_executed && ack_en_q))
					pend_d = 1'b0;
				cnt_d   = 10'h001;
				state_d = sdh_pkg::SDH_IDLE;
			end
			default:
				state_d = sdh_pkg::SDH_IDLE;
		endcase
	end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_q    <= sdh_pkg::SDH_IDLE;
			cnt_q      <= sdh_pkg::CNT_RESET;
			idle_q     <= sdh_pkg::CNT_RESET;
			left_q     <= sdh_pkg::BITN_RESET;
			shift_q    <= 16'h0000;
			txmode_q   <= 1'b0;
			ack_en_q   <= 1'b0;
			pend_q     <= 1'b0;
			gap_ok_q   <= 1'b1;
			rx_valid_q <= 1'b0;
			tx_done_q  <= 1'b0;
			tmo_q      <= 1'b0;
			drv_q      <= 1'b0;
			oe_q       <= 1'b0;
			in_rst_q   <= 1'b1;
			strap_q    <= 1'b1;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			idle_q     <= idle_d;
			left_q     <= left_d;
			shift_q    <= shift_d;
			txmode_q   <= txmode_d;
			ack_en_q   <= ack_en_d;
			pend_q     <= pend_d;
			gap_ok_q   <= gap_ok_d;
			rx_valid_q <= rx_valid_d;
			tx_done_q  <= tx_done_d;
			tmo_q      <= tmo_d;
			drv_q      <= drv_d;
			oe_q       <= oe_d;
			in_rst_q   <= 1'b0;
			strap_q    <= strap_d;
		end
	end

	// strap taken on the first cycle after release; the synchroniser still shows the pin as held in reset
	always_comb
		strap_d = in_rst_q ? pin_level : strap_q;
	assign o_pin         = drv_q;
	assign o_pin_oe      = oe_q & ~i_rst;
	assign o_mode_strap  = strap_q;
	assign o_rx_valid    = rx_valid_q;
	assign o_rx_data     = shift_q;
	assign o_tx_done     = tx_done_q;
	assign o_ack_enabled = ack_en_q;
	assign o_ack_pending = pend_q;
	assign o_timeout     = tmo_q;
	assign o_busy        = (state_q != sdh_pkg::SDH_IDLE) | (left_q != 5'h00);
endmodule

// ===== test/sdh_chk.sv
// sdh_chk: concurrent checks on the ports of the serial bit engine
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ns
module sdh_chk
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_pin,
	input wire logic        o_pin,
	input wire logic        o_pin_oe,
	input wire logic        i_ack_enable,
	input wire logic        o_rx_valid,
	input wire logic        i_cmd_executed,
	input wire logic        i_cpu_stop,
	input wire logic        o_ack_enabled,
	input wire logic        o_ack_pending,
	input wire logic        o_timeout
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [5:0] gap_q, gap_d;
	logic [9:0] hi_q, hi_d;
	// both counters saturate so a long idle never wraps into a false early value
	always_comb
	begin
		gap_d = o_rx_valid ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3f};
		hi_d = !i_pin ? 10'h000 : hi_q + {9'h000, hi_q != 10'h3ff};
	end
	always_ff @(posedge i_clk)
	begin
		gap_q <= i_rst ? 6'h3f : gap_d;
		hi_q <= i_rst ? 10'h000 : hi_d;
	end
	a_speedup_brief: assert property (o_pin_oe && o_pin |=> !(o_pin_oe && o_pin)) else $error("speedup too long");
	a_reset_quiet: assert property ($fell(i_rst) |-> !o_ack_enabled && !o_pin_oe) else $error("reset state");
	a_ack_turns_on: assert property (i_ack_enable |=> o_ack_enabled) else $error("ack enable");
	a_exec_pends: assert property (i_cmd_executed && o_ack_enabled |=> o_ack_pending) else $error("no pending");
	a_stop_drops: assert property (i_cpu_stop && !i_cmd_executed |=> !o_ack_pending) else $error("stop");
	a_ack_shape: assert property ($rose(o_pin_oe) && $past(o_ack_pending) |->
		!o_pin ##16 (o_pin_oe && o_pin)) else $error("ack shape");
	a_ack_gap: assert property ($rose(o_pin_oe) && $past(o_ack_pending) |-> gap_q >= 6'd30)
		else $error("ack too early");
	a_timeout_idle: assert property (o_timeout |-> hi_q >= 10'd500) else $error("early timeout");
	c_rx: cover property (o_rx_valid);
	c_ack: cover property ($rose(o_pin_oe) && $past(o_ack_pending));
	c_tmo: cover property (o_timeout);
endmodule
bind sdh_serial sdh_chk chk_u (.i_clk, .i_rst, .i_pin, .o_pin, .o_pin_oe, .i_ack_enable, .o_rx_valid,
	.i_cmd_executed, .i_cpu_stop, .o_ack_enabled, .o_ack_pending, .o_timeout);

// ===== test/sdh_probe.sv
// sdh_probe: behavioural debug probe on the host side of the debug pin
// assumes the bench resolves the wire from both drivers with a pull-up
`timescale 1ns/1ns
module sdh_probe
(
	input  wire logic i_clk,
	input  wire logic i_pin,
	output logic      o_pin,
	output logic      o_pin_oe
);
	initial
	begin
		o_pin = 1'b0;
		o_pin_oe = 1'b0;
	end
	// 20-cycle bit times leave slack past the target's 16-cycle bit end
	task automatic send(input logic [15:0] d, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge i_clk) #1;
			o_pin_oe = 1'b1;
			repeat (d[i] ? 4 : 14) @(posedge i_clk);
			#1 o_pin = 1'b1;
			@(posedge i_clk) #1;
			o_pin_oe = 1'b0;
			o_pin = 1'b0;
			repeat (d[i] ? 14 : 4) @(posedge i_clk);
		end
	endtask
	task automatic recv(input int n, output logic [15:0] d);
		d = 16'h0000;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(posedge i_clk) #1;
			o_pin_oe = 1'b1;
			repeat (3) @(posedge i_clk);
			#1 o_pin_oe = 1'b0;
			repeat (8) @(posedge i_clk);
			#1 d[i] = i_pin;
			repeat (9) @(posedge i_clk);
		end
	endtask
	// long low then one driven-high cycle; the target has no abort logic, so a pending command stays pending
	task automatic abort();
		@(posedge i_clk) #1;
		o_pin_oe = 1'b1;
		repeat (130) @(posedge i_clk);
		#1 o_pin = 1'b1;
		@(posedge i_clk) #1;
		o_pin_oe = 1'b0;
		o_pin = 1'b0;
	endtask
	// holds the pin low, e.g. as a mode strap during reset
	task automatic hold(input logic lo);
		o_pin_oe = lo;
		o_pin = 1'b0;
	endtask
endmodule

// ===== test/testbench.sv
// testbench: self-checking bench for the serial bit engine and acknowledge pulse
// assumes a pulled-up wire shared by the engine and the probe model
`timescale 1ns/1ns
module testbench;
	logic        clk, rst, ack_en, ack_dis, rx_arm, tx_load, exe, stop;
	logic [4:0]  rx_bits, tx_bits;
	logic [15:0] tx_data, rx_data, got;
	logic        d_pin, d_oe, strap, rx_v, tx_d, ack_on, pend, tmo, h_pin, h_oe, rx_s, tx_s, tmo_s, busy;
	int          n_fail, n_tests, k;
	wire         pin = d_oe ? d_pin : (h_oe ? h_pin : 1'b1);
	sdh_serial dut_u (.i_clk(clk), .i_rst(rst), .i_pin(pin), .o_pin(d_pin), .o_pin_oe(d_oe),
		.o_mode_strap(strap), .i_ack_enable(ack_en), .i_ack_disable(ack_dis), .i_rx_arm(rx_arm),
		.i_rx_bits(rx_bits), .o_rx_valid(rx_v), .o_rx_data(rx_data), .i_tx_load(tx_load),
		.i_tx_bits(tx_bits), .i_tx_data(tx_data), .o_tx_done(tx_d), .i_cmd_executed(exe),
		.i_cpu_stop(stop), .o_ack_enabled(ack_on), .o_ack_pending(pend), .o_timeout(tmo), .o_busy(busy));
	sdh_probe h_u (.i_clk(clk), .i_pin(pin), .o_pin(h_pin), .o_pin_oe(h_oe));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// one-cycle pulses are caught here so a task busy on the wire cannot miss them
	always @(posedge clk)
	begin
		if (rx_v) rx_s <= 1'b1;
		if (tx_d) tx_s <= 1'b1;
		if (tmo) tmo_s <= 1'b1;
	end
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (!ok)
		begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_flag(ref logic f, input int n);
		k = 0;
		while (f !== 1'b1 && k < n)
		begin
			tick(1);
			k++;
		end
		if (k >= n)
		begin
			n_fail++;
			$display("[FAIL] %0t wait ran out", $time);
			conclude();
		end
	endtask
	task automatic t_rx(input logic [7:0] d);
		tick(1);
		rx_bits = 5'h08;
		rx_arm = 1'b1;
		tick(1);
		rx_arm = 1'b0;
		rx_s = 1'b0;
		h_u.send({8'h00, d}, 8);
		wait_flag(rx_s, 50);
		chk(rx_data[7:0] === d, "received byte");
	endtask
	task automatic t_tx();
		tx_bits = 5'h08;
		tx_data = 16'h00b4;
		tx_load = 1'b1;
		tick(1);
		tx_load = 1'b0;
		tx_s = 1'b0;
		h_u.recv(8, got);
		tick(4);
		chk(got[7:0] === 8'hb4 && tx_s === 1'b1, "sent byte");
	endtask
	task automatic t_ack();
		ack_en = 1'b1;
		tick(1);
		ack_en = 1'b0;
		chk(ack_on === 1'b1, "handshake on");
		t_rx(8'h3c);
		exe = 1'b1;
		tick(1);
		exe = 1'b0;
		wait_flag(d_oe, 200);
		chk(k >= 28, "ack too soon");
		k = 0;
		while (d_oe === 1'b1 && d_pin === 1'b0 && k < 40)
		begin
			tick(1);
			k++;
		end
		chk(k == 16 && d_pin === 1'b1, "ack pulse");
		tx_bits = 5'h10;
		tx_data = 16'h5a3c;
		tx_load = 1'b1;
		tick(1);
		tx_load = 1'b0;
		h_u.recv(16, got);
		chk(got[15:8] === 8'h5a && got[7:0] === 8'h3c, "even byte read");
	endtask
	task automatic t_stop();
		t_rx(8'h81);
		exe = 1'b1;
		tick(1);
		exe = 1'b0;
		stop = 1'b1;
		tick(1);
		stop = 1'b0;
		k = 0;
		repeat (100)
		begin
			tick(1);
			if (d_oe === 1'b1) k++;
		end
		chk(k == 0 && pend === 1'b0, "stop discard");
		h_u.abort();
		ack_dis = 1'b1;
		tick(1);
		ack_dis = 1'b0;
		exe = 1'b1;
		tick(1);
		exe = 1'b0;
		tick(1);
		chk(ack_on === 1'b0 && pend === 1'b0, "handshake off");
	endtask
	task automatic t_timeout();
		tick(1);
		rx_arm = 1'b1;
		tick(1);
		rx_arm = 1'b0;
		chk(busy === 1'b1, "armed not busy");
		h_u.send(16'h0005, 3);
		tmo_s = 1'b0;
		wait_flag(tmo_s, 700);
		chk(k >= 470 && busy === 1'b0, "early timeout");
		t_rx(8'h96);
	endtask
	task automatic t_strap();
		rst = 1'b1;
		h_u.hold(1'b1);
		tick(20);
		rst = 1'b0;
		h_u.hold(1'b0);
		tick(2);
		chk(strap === 1'b0 && ack_on === 1'b0 && d_oe === 1'b0, "strap low");
	endtask
	initial
	begin
		{ack_en, ack_dis, rx_arm, tx_load, exe, stop, rx_s, tx_s, tmo_s} = 9'h000;
		rx_bits = 5'h08;
		tx_bits = 5'h00;
		tx_data = 16'h0000;
		n_fail = 0;
		n_tests = 0;
		rst = 1'b1;
		tick(20);
		rst = 1'b0;
		tick(2);
		chk(ack_on === 1'b0 && strap === 1'b1 && d_oe === 1'b0, "reset state");
		t_rx(8'ha5);
		t_tx();
		t_ack();
		t_stop();
		t_timeout();
		t_strap();
		conclude();
	end
endmodule
